// [core/irs_defs.svh]
/*
  constants of the interrupt return sequencer: register indices, field
  positions, reset values and sizes. assumes inclusion by bare name.
*/
// What this block does
// - two returns, only one clears cache valids
// - invalidating return spares locked cache regions
// - finish single access, wait for multiples
// - block traps from invalidate to multiple start
// - copy saved status into current status
// - hardware driven status bits stay live
// - restart single access when valid, single
// - no multiple restart at single point
// - first fetch from execute restart, branch
// - second fetch from decode restart, branch unless the pair was sequential
// - advance both restart instructions together
// - restart multiple transfer after both fetches
// - finally re-enable traps per current status
// - untouched sequential restart pair fetches sequentially
// - freeze holds restart, channel, arithmetic state
// - frozen loads leave byte pointer alone
// - frozen: carry bit not updated
// - frozen: divide flag not updated
// - vectors below 64 supervisor only
// - supervisor assert emulates hardware vector trap
// - restart registers capture decode, execute addresses
// - report register captures write-back address
// - trap saves status and sets freeze
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH

`define IRS_REG_CPS 4'h0
`define IRS_REG_OPS 4'h1
`define IRS_REG_PC0 4'h2
`define IRS_REG_PC1 4'h3
`define IRS_REG_PC2 4'h4
`define IRS_REG_CHA 4'h5
`define IRS_REG_CHD 4'h6
`define IRS_REG_CHC 4'h7
`define IRS_REG_ALU 4'h8
`define IRS_REG_BP 4'h9
`define IRS_REG_STAT 4'hA

`define IRS_DA_BIT 0
`define IRS_DI_BIT 1
`define IRS_SM_BIT 4
`define IRS_FZ_BIT 10
`define IRS_IP_BIT 14
`define IRS_CV_BIT 0
`define IRS_NN_BIT 1
`define IRS_ML_BIT 2
`define IRS_CARRY_BIT 5
`define IRS_DIVF_BIT 6

`define IRS_CPS_RST 32'h0000_0410
`define IRS_HW_VEC_LIMIT 8'h40
`define IRS_WORD_STEP 32'h0000_0004
`define IRS_IC_LINES 64
`define IRS_IC_REGIONS 2

`endif

// [core/irs_pkg.sv]
/*
  types of the interrupt return sequencer.
  assumes nothing beyond a sv compiler.
*/
package irs_pkg;
  typedef enum logic [9:0] {
    IRS_IDLE = 10'b00_0000_0001,
    IRS_DRAIN = 10'b00_0000_0010,
    IRS_INVAL = 10'b00_0000_0100,
    IRS_COPY = 10'b00_0000_1000,
    IRS_ACC = 10'b00_0001_0000,
    IRS_FETCH1 = 10'b00_0010_0000,
    IRS_FETCH2 = 10'b00_0100_0000,
    IRS_ADV = 10'b00_1000_0000,
    IRS_MULTI = 10'b01_0000_0000,
    IRS_ENABLE = 10'b10_0000_0000
  } irs_state_t;

  typedef struct packed {
    logic req;
    logic branch;
    logic [31:0] addr;
  } irs_fetch_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] ctl;
  } irs_chan_t;
endpackage : irs_pkg

// [core/irs_valid_clear.sv]
/*
  walks every instruction cache line and strobes a valid clear for each
  line whose region is not locked. assumes lines split evenly into regions.
*/
`timescale 1ns/1ps
`include "irs_defs.svh"
module irs_valid_clear #(
  parameter int LINES = `IRS_IC_LINES,
  parameter int REGIONS = `IRS_IC_REGIONS
) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic start, // begin a walk
  input wire logic [REGIONS-1:0] locked, // region lock flags
  output logic [$clog2(LINES)-1:0] clrIdx_q, // line to clear
  output logic clrEn_q, // clear strobe
  output logic busy_q, // walk running
  output logic done_q // walk finished
);
  localparam int IW = $clog2(LINES);
  localparam int RW = (REGIONS > 1) ? $clog2(REGIONS) : 1;
  localparam int RSH = IW - RW;
  logic [IW-1:0] idx_q, idx_d, clrIdx_d;
  logic clrEn_d, busy_d, done_d;
  logic [RW-1:0] region;

  always_comb begin
    idx_d = idx_q;
    busy_d = busy_q;
    clrEn_d = 1'b0;
    clrIdx_d = clrIdx_q;
    done_d = 1'b0;
    region = RW'(idx_q >> RSH);
    if (busy_q) begin
      clrIdx_d = idx_q;
      clrEn_d = !locked[region];
      idx_d = idx_q + 1'b1;
      if (idx_q == IW'(LINES - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end else if (start) begin
      busy_d = 1'b1;
      idx_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idx_q <= '0;
      busy_q <= 1'b0;
      clrEn_q <= 1'b0;
      clrIdx_q <= '0;
      done_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      busy_q <= busy_d;
      clrEn_q <= clrEn_d;
      clrIdx_q <= clrIdx_d;
      done_q <= done_d;
    end
  end

  chk_locked_spared: assert property (@(posedge clk) disable iff (srst)
    busy_q && locked[region] |=> !clrEn_q)
    else $error("locked line was cleared");
endmodule : irs_valid_clear

// [core/irs_return_seq.sv]
/*
  exception return sequencer with the frozen restart state, status copy,
  byte pointer and arithmetic status, and supervisor assert vetting.
  assumes pipeline, cache and memory bus on the same clock.
*/
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "irs_defs.svh"
module irs_return_seq #(
  parameter int LINES = `IRS_IC_LINES,
  parameter int REGIONS = `IRS_IC_REGIONS
) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic [3:0] regAddr, // register index
  input wire logic [31:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [31:0] regRdata_q, // read data, next cycle
  input wire logic retReq, // return op issued
  input wire logic retInv, // return_and_flush_op variant
  input wire logic memBusy, // single access in flight
  input wire logic multiBusy, // multiple transfer running
  input wire logic [REGIONS-1:0] icLocked, // locked cache regions
  output logic [$clog2(LINES)-1:0] icClrIdx_q, // cache line index
  output logic icClrEn_q, // clear valid strobe
  output irs_pkg::irs_fetch_t fetch_q, // restart fetch request
  input wire logic fetchDone, // fetch answered
  output logic accReq_q, // restart single access
  input wire logic accAck, // single access started
  output logic multiReq_q, // restart multiple transfer
  input wire logic multiAck, // multiple transfer started
  output irs_pkg::irs_chan_t chan_q, // channel registers
  output logic pipeAdv_q, // load execute and decode
  output logic retDone_q, // return finished
  output logic trapBlock_q, // traps held off
  output logic [31:0] curStatus_q, // current status
  output logic [31:0] aluStatus_q, // arithmetic status
  output logic [31:0] bytePtr_q, // byte pointer
  input wire logic trapTake, // trap entry taken
  input wire logic hwIntPend, // live interrupt pending
  input wire logic decAdv, // instruction enters decode
  input wire logic exeAdv, // instruction enters execute
  input wire logic wbAdv, // instruction enters write-back
  input wire logic [31:0] decPc, // its address
  input wire logic [31:0] exePc, // its address
  input wire logic [31:0] wbPc, // its address
  input wire logic chWe, // channel update
  input wire irs_pkg::irs_chan_t chIn, // channel value
  input wire logic aluWe, // arithmetic status write
  input wire logic [31:0] aluIn, // its value
  input wire logic carryWe, // carry update
  input wire logic carryIn, // carry value
  input wire logic divWe, // divide step flag update
  input wire logic divIn, // divide flag value
  input wire logic lsSetBp, // load/store with set byte pointer
  input wire logic [31:0] lsBp, // byte pointer value
  input wire logic asrtOp, // assert op executes
  input wire logic [7:0] asrtVec, // its vector
  input wire logic asrtFires, // its condition traps
  output logic protViol_q, // user named hardware vector
  output logic vecTrap_q, // assert trap raised
  output logic [7:0] trapVec_q // vector of that trap
);
  import irs_pkg::*;

  function automatic logic [31:0] wordAddr(input logic [31:0] a);
    return {a[31:2], 2'b00};
  endfunction : wordAddr

  function automatic logic chanRestart(input logic [31:0] ctl, input logic multi);
    return ctl[`IRS_CV_BIT] && !ctl[`IRS_NN_BIT] && (ctl[`IRS_ML_BIT] == multi);
  endfunction : chanRestart

  //////////////////////////////////////////////////////////////////////////
  // return sequencer
  irs_state_t state_q, state_d;
  irs_fetch_t fetch_d;
  logic inv_q, inv_d, invStart_q, invStart_d;
  logic accReq_d, multiReq_d, pipeAdv_d, retDone_d, trapBlock_d;
  logic doCopy, invBusy;
  logic seq_q, seq_d;
  logic [31:0] cps_d, ops_q, ops_d, pc0_q, pc0_d, pc1_q, pc1_d, pc2_q, pc2_d;
  logic [31:0] alu_d, bp_d;
  irs_chan_t chan_d;
  logic fz;

  assign fz = curStatus_q[`IRS_FZ_BIT];

  irs_valid_clear #(.LINES(LINES), .REGIONS(REGIONS)) uClear (
    .clk(clk),
    .srst(srst),
    .start(invStart_q),
    .locked(icLocked),
    .clrIdx_q(icClrIdx_q),
    .clrEn_q(icClrEn_q),
    .busy_q(invBusy),
    .done_q()
  );

  always_comb begin
    state_d = state_q;
    inv_d = inv_q;
    fetch_d = fetch_q;
    accReq_d = accReq_q;
    multiReq_d = multiReq_q;
    pipeAdv_d = 1'b0;
    retDone_d = 1'b0;
    invStart_d = 1'b0;
    doCopy = 1'b0;
    case (state_q)
      IRS_IDLE: begin
        if (retReq) begin
          inv_d = retInv;
          state_d = IRS_DRAIN;
        end
      end
      IRS_DRAIN: begin
        if (!memBusy && !multiBusy) begin
          invStart_d = inv_q;
          state_d = IRS_INVAL;
        end
      end
      IRS_INVAL: begin
        if (!invStart_q && !invBusy) begin
          state_d = IRS_COPY;
        end
      end
      IRS_COPY: begin
        doCopy = 1'b1;
        if (chanRestart(chan_q.ctl, 1'b0)) begin
          accReq_d = 1'b1;
          state_d = IRS_ACC;
        end else begin
          fetch_d = '{req: 1'b1, branch: 1'b1, addr: wordAddr(pc1_q)};
          state_d = IRS_FETCH1;
        end
      end
      IRS_ACC: begin
        if (accAck) begin
          accReq_d = 1'b0;
          fetch_d = '{req: 1'b1, branch: 1'b1, addr: wordAddr(pc1_q)};
          state_d = IRS_FETCH1;
        end
      end
      IRS_FETCH1: begin
        if (fetchDone) begin
          fetch_d = '{req: 1'b1, branch: !seq_q, addr: wordAddr(pc0_q)};
          state_d = IRS_FETCH2;
        end
      end
      IRS_FETCH2: begin
        if (fetchDone) begin
          fetch_d.req = 1'b0;
          pipeAdv_d = 1'b1;
          state_d = IRS_ADV;
        end
      end
      IRS_ADV: begin
        if (chanRestart(chan_q.ctl, 1'b1)) begin
          multiReq_d = 1'b1;
          state_d = IRS_MULTI;
        end else begin
          state_d = IRS_ENABLE;
        end
      end
      IRS_MULTI: begin
        if (multiAck) begin
          multiReq_d = 1'b0;
          state_d = IRS_ENABLE;
        end
      end
      IRS_ENABLE: begin
        retDone_d = 1'b1;
        state_d = IRS_IDLE;
      end
      default: begin
        state_d = IRS_IDLE;
      end
    endcase
    // current status gating takes over again once enable is reached
    trapBlock_d = !(state_d == IRS_IDLE || state_d == IRS_DRAIN ||
                    state_d == IRS_ENABLE);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= IRS_IDLE;
      inv_q <= 1'b0;
      invStart_q <= 1'b0;
      fetch_q <= '0;
      accReq_q <= 1'b0;
      multiReq_q <= 1'b0;
      pipeAdv_q <= 1'b0;
      retDone_q <= 1'b0;
      trapBlock_q <= 1'b0;
    end else begin
      state_q <= state_d;
      inv_q <= inv_d;
      invStart_q <= invStart_d;
      fetch_q <= fetch_d;
      accReq_q <= accReq_d;
      multiReq_q <= multiReq_d;
      pipeAdv_q <= pipeAdv_d;
      retDone_q <= retDone_d;
      trapBlock_q <= trapBlock_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status, restart and frozen registers
  logic pipeOn;
  // pipeline capture pauses while the sequencer owns the restart pair
  assign pipeOn = !fz && (state_q == IRS_IDLE);

  always_comb begin
    cps_d = curStatus_q;
    ops_d = ops_q;
    pc0_d = pc0_q;
    pc1_d = pc1_q;
    pc2_d = pc2_q;
    chan_d = chan_q;
    alu_d = aluStatus_q;
    bp_d = bytePtr_q;
    seq_d = seq_q;
    if (pipeOn) begin
      if (decAdv) pc0_d = wordAddr(decPc);
      if (exeAdv) pc1_d = wordAddr(exePc);
      if (wbAdv) pc2_d = wordAddr(wbPc);
      if (chWe) chan_d = chIn;
      if (aluWe) alu_d = aluIn;
      if (carryWe) alu_d[`IRS_CARRY_BIT] = carryIn;
      if (divWe) alu_d[`IRS_DIVF_BIT] = divIn;
    end
    if (lsSetBp && !fz) bp_d = lsBp;
    if (regWr) begin
      case (regAddr)
        `IRS_REG_CPS: cps_d = regWdata;
        `IRS_REG_OPS: ops_d = regWdata;
        `IRS_REG_PC0: begin
          pc0_d = wordAddr(regWdata);
          seq_d = 1'b0;
        end
        `IRS_REG_PC1: begin
          pc1_d = wordAddr(regWdata);
          seq_d = 1'b0;
        end
        `IRS_REG_PC2: pc2_d = wordAddr(regWdata);
        `IRS_REG_CHA: chan_d.addr = regWdata;
        `IRS_REG_CHD: chan_d.data = regWdata;
        `IRS_REG_CHC: chan_d.ctl = regWdata;
        `IRS_REG_ALU: alu_d = regWdata;
        `IRS_REG_BP: bp_d = regWdata;
        default: begin
        end
      endcase
    end
    if (trapTake && !trapBlock_q) begin
      ops_d = curStatus_q;
      cps_d[`IRS_FZ_BIT] = 1'b1;
      seq_d = (pc0_q == pc1_q + `IRS_WORD_STEP);
    end
    if (doCopy) cps_d = ops_q;
    cps_d[`IRS_IP_BIT] = hwIntPend;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      curStatus_q <= `IRS_CPS_RST;
      ops_q <= `IRS_CPS_RST;
      pc0_q <= '0;
      pc1_q <= '0;
      pc2_q <= '0;
      chan_q <= '0;
      aluStatus_q <= '0;
      bytePtr_q <= '0;
      seq_q <= 1'b0;
    end else begin
      curStatus_q <= cps_d;
      ops_q <= ops_d;
      pc0_q <= pc0_d;
      pc1_q <= pc1_d;
      pc2_q <= pc2_d;
      chan_q <= chan_d;
      aluStatus_q <= alu_d;
      bytePtr_q <= bp_d;
      seq_q <= seq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read port and assert vetting
  logic [31:0] rdata_d;
  logic protViol_d, vecTrap_d;
  logic [7:0] trapVec_d;

  always_comb begin
    rdata_d = '0;
    if (regRd) begin
      case (regAddr)
        `IRS_REG_CPS: rdata_d = curStatus_q;
        `IRS_REG_OPS: rdata_d = ops_q;
        `IRS_REG_PC0: rdata_d = pc0_q;
        `IRS_REG_PC1: rdata_d = pc1_q;
        `IRS_REG_PC2: rdata_d = pc2_q;
        `IRS_REG_CHA: rdata_d = chan_q.addr;
        `IRS_REG_CHD: rdata_d = chan_q.data;
        `IRS_REG_CHC: rdata_d = chan_q.ctl;
        `IRS_REG_ALU: rdata_d = aluStatus_q;
        `IRS_REG_BP: rdata_d = bytePtr_q;
        `IRS_REG_STAT: rdata_d = {20'h0_0000, seq_q, inv_q, state_q};
        default: rdata_d = '0;
      endcase
    end
    protViol_d = 1'b0;
    vecTrap_d = 1'b0;
    trapVec_d = trapVec_q;
    if (asrtOp) begin
      if (asrtVec < `IRS_HW_VEC_LIMIT && !curStatus_q[`IRS_SM_BIT]) begin
        protViol_d = 1'b1;
      end else if (asrtFires) begin
        vecTrap_d = 1'b1;
        trapVec_d = asrtVec;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata_q <= '0;
      protViol_q <= 1'b0;
      vecTrap_q <= 1'b0;
      trapVec_q <= '0;
    end else begin
      regRdata_q <= rdata_d;
      protViol_q <= protViol_d;
      vecTrap_q <= vecTrap_d;
      trapVec_q <= trapVec_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_drain_waits: assert property (@(posedge clk) disable iff (srst)
    state_q == IRS_DRAIN && (memBusy || multiBusy) |=> state_q == IRS_DRAIN)
    else $error("return left drain with traffic open");
  chk_block_window: assert property (@(posedge clk) disable iff (srst)
    state_q inside {IRS_INVAL, IRS_COPY, IRS_ACC, IRS_FETCH1, IRS_FETCH2,
                    IRS_ADV, IRS_MULTI} |-> trapBlock_q)
    else $error("traps open during return");
  chk_plain_noclear: assert property (@(posedge clk) disable iff (srst)
    state_q == IRS_DRAIN && !inv_q |=> !invStart_q)
    else $error("plain return started a cache clear");
  chk_copy_status: assert property (@(posedge clk) disable iff (srst)
    state_q == IRS_COPY |=> curStatus_q[`IRS_FZ_BIT] == $past(ops_q[`IRS_FZ_BIT]))
    else $error("saved status not copied");
  chk_clear_first: assert property (@(posedge clk) disable iff (srst)
    $rose(fetch_q.req) |-> !invBusy && !icClrEn_q)
    else $error("restart fetch before cache clear ended");
  chk_fetch_order: assert property (@(posedge clk) disable iff (srst)
    state_q == IRS_FETCH1 && fetchDone |=> fetch_q.addr == pc0_q && fetch_q.req)
    else $error("second restart fetch wrong");
  chk_single_restart: assert property (@(posedge clk) disable iff (srst)
    state_q == IRS_COPY && chanRestart(chan_q.ctl, 1'b0) |=> accReq_q && !fetch_q.req)
    else $error("single access not restarted");
  chk_multi_late: assert property (@(posedge clk) disable iff (srst)
    multiReq_q |-> state_q == IRS_MULTI)
    else $error("multiple restart out of place");
  chk_pc_frozen: assert property (@(posedge clk) disable iff (srst)
    fz && !regWr |=> $stable(pc0_q) && $stable(pc1_q) && $stable(aluStatus_q))
    else $error("frozen register changed");
  chk_bp_frozen: assert property (@(posedge clk) disable iff (srst)
    fz && lsSetBp && !regWr |=> $stable(bytePtr_q))
    else $error("byte pointer moved while frozen");
  chk_user_vector: assert property (@(posedge clk) disable iff (srst)
    asrtOp && asrtVec < `IRS_HW_VEC_LIMIT && !curStatus_q[`IRS_SM_BIT]
    |=> protViol_q && !vecTrap_q)
    else $error("user assert named hardware vector");
  chk_trap_freeze: assert property (@(posedge clk) disable iff (srst)
    trapTake && !trapBlock_q && !(state_q == IRS_COPY)
    |=> curStatus_q[`IRS_FZ_BIT] && ops_q == $past(curStatus_q))
    else $error("trap entry did not freeze");
  chk_align: assert property (@(posedge clk) disable iff (srst)
    pc0_q[1:0] == 2'b00 && pc1_q[1:0] == 2'b00 && pc2_q[1:0] == 2'b00)
    else $error("restart address unaligned");
endmodule : irs_return_seq

// [test/irs_partner.sv]
/*
  behavioural instruction cache and memory bus: answers restart fetches,
  single accesses and multiple transfers after a set lag, and logs them.
  assumes one clock and one request in flight at a time.
*/
`timescale 1ns/1ps
module irs_partner #(
  parameter int LINES = 64,
  parameter int REGIONS = 2
) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic clrLog, // zero the log
  input wire logic [3:0] lag, // answer delay in cycles
  input wire irs_pkg::irs_fetch_t fetch, // fetch request
  output logic fetchDone, // fetch answered
  input wire logic accReq, // single access
  output logic accAck, // access started
  input wire logic multiReq, // multiple transfer
  output logic multiAck, // transfer started
  input wire logic icClrEn, // clear strobe
  input wire logic [$clog2(LINES)-1:0] icClrIdx, // cleared line
  input wire logic [REGIONS-1:0] icLocked // region locks
);
  import irs_pkg::*;
  logic [3:0] waitCnt_q;
  logic pending;
  int fCnt, accCnt, multiCnt, clrCnt, lockHit;
  logic [31:0] fAddr [2];
  logic fBr [2];
  int fClr [2];
  assign pending = (fetch.req && !fetchDone) || (accReq && !accAck) || (multiReq && !multiAck);
  initial begin
    {fetchDone, accAck, multiAck} = 3'h0;
  end
  always @(posedge clk) begin
    {fetchDone, accAck, multiAck} <= 3'h0;
    if (srst || clrLog) begin
      waitCnt_q <= 4'h0;
      {fCnt, accCnt, multiCnt, clrCnt, lockHit} <= '0;
    end else begin
      if (icClrEn) begin
        clrCnt <= clrCnt + 1;
        if (icLocked[icClrIdx / (LINES / REGIONS)]) lockHit <= lockHit + 1;
      end
      if (pending && waitCnt_q < lag) begin
        waitCnt_q <= waitCnt_q + 4'h1;
      end else if (pending) begin
        waitCnt_q <= 4'h0;
        if (fetch.req) begin
          fetchDone <= 1'b1;
          if (fCnt < 2) begin
            fAddr[fCnt] <= fetch.addr;
            fBr[fCnt] <= fetch.branch;
            fClr[fCnt] <= clrCnt;
          end
          fCnt <= fCnt + 1;
        end else if (accReq) begin
          accAck <= 1'b1;
          accCnt <= accCnt + 1;
        end else begin
          multiAck <= 1'b1;
          multiCnt <= multiCnt + 1;
        end
      end
    end
  end
endmodule : irs_partner

// [test/tb_top.sv]
/*
  self-checking bench of the return sequencer with the cache and bus partner.
  assumes the design's register indices and status bit positions.
*/
`timescale 1ns/1ps
`include "irs_defs.svh"
module tb_top;
  import irs_pkg::*;
  logic clk, srst, regWr, regRd, retReq, retInv, memBusy, multiBusy, fetchDone, accAck;
  logic multiAck, trapTake, hwIntPend, decAdv, exeAdv, wbAdv, chWe, aluWe, carryWe, carryIn;
  logic divWe, divIn, lsSetBp, asrtOp, asrtFires, clrLog, icClrEn, accReq, multiReq;
  logic pipeAdv, retDone, trapBlock, protViol, vecTrap;
  logic [3:0] regAddr, lag;
  logic [31:0] regWdata, regRdata, curStatus, aluStatus, bytePtr, decPc, exePc, wbPc, aluIn, lsBp;
  logic [1:0] icLocked;
  logic [5:0] icClrIdx;
  logic [7:0] asrtVec, trapVec;
  irs_fetch_t fetch;
  irs_chan_t chan, chIn;
  int errors, samplesChecked;

  irs_return_seq #(.LINES(64), .REGIONS(2)) i_dut (.clk(clk), .srst(srst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata_q(regRdata), .retReq(retReq), .retInv(retInv), .memBusy(memBusy),
    .multiBusy(multiBusy), .icLocked(icLocked), .icClrIdx_q(icClrIdx), .icClrEn_q(icClrEn),
    .fetch_q(fetch), .fetchDone(fetchDone), .accReq_q(accReq), .accAck(accAck),
    .multiReq_q(multiReq), .multiAck(multiAck), .chan_q(chan), .pipeAdv_q(pipeAdv),
    .retDone_q(retDone), .trapBlock_q(trapBlock), .curStatus_q(curStatus),
    .aluStatus_q(aluStatus), .bytePtr_q(bytePtr), .trapTake(trapTake), .hwIntPend(hwIntPend),
    .decAdv(decAdv), .exeAdv(exeAdv), .wbAdv(wbAdv), .decPc(decPc), .exePc(exePc),
    .wbPc(wbPc), .chWe(chWe), .chIn(chIn), .aluWe(aluWe), .aluIn(aluIn), .carryWe(carryWe),
    .carryIn(carryIn), .divWe(divWe), .divIn(divIn), .lsSetBp(lsSetBp), .lsBp(lsBp),
    .asrtOp(asrtOp), .asrtVec(asrtVec), .asrtFires(asrtFires), .protViol_q(protViol),
    .vecTrap_q(vecTrap), .trapVec_q(trapVec));

  irs_partner #(.LINES(64), .REGIONS(2)) i_part (.clk(clk), .srst(srst), .clrLog(clrLog),
    .lag(lag), .fetch(fetch), .fetchDone(fetchDone), .accReq(accReq), .accAck(accAck),
    .multiReq(multiReq), .multiAck(multiAck), .icClrEn(icClrEn), .icClrIdx(icClrIdx),
    .icLocked(icLocked));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdata, exp);
  endtask : rdchk

  task automatic rd_state(input logic [31:0] p0, p1, p2, ca, al, bp);
    rdchk(`IRS_REG_PC0, p0);
    rdchk(`IRS_REG_PC1, p1);
    rdchk(`IRS_REG_PC2, p2);
    rdchk(`IRS_REG_CHA, ca);
    rdchk(`IRS_REG_ALU, al);
    rdchk(`IRS_REG_BP, bp);
  endtask : rd_state

  // one of every pipeline update, then carry and divide flag
  task automatic pipe(input logic [31:0] pc, input logic [31:0] v);
    @(posedge clk);
    {decAdv, exeAdv, wbAdv, chWe, aluWe, lsSetBp} <= 6'h3F;
    decPc <= pc + 32'h0000_0004;
    exePc <= pc;
    wbPc <= pc - 32'h0000_0004;
    chIn <= {v, v, 32'h0000_0000};
    aluIn <= v;
    lsBp <= v;
    @(posedge clk);
    {decAdv, exeAdv, wbAdv, chWe, aluWe, lsSetBp} <= 6'h00;
    {carryWe, divWe} <= 2'h3;
    {carryIn, divIn} <= {2{!v[8]}};
    @(posedge clk);
    {carryWe, divWe} <= 2'h0;
  endtask : pipe

  task automatic t_freeze();
    wr(`IRS_REG_CPS, 32'h0000_0010);
    pipe(32'h0000_0100, 32'h0000_0A00);
    rd_state(32'h0000_0104, 32'h0000_0100, 32'h0000_00FC, 32'h0000_0A00, 32'h0000_0A60,
      32'h0000_0A00);
    @(posedge clk);
    trapTake <= 1'b1;
    @(posedge clk);
    trapTake <= 1'b0;
    rdchk(`IRS_REG_OPS, 32'h0000_0010);
    rdchk(`IRS_REG_CPS, 32'h0000_0410);
    rdchk(`IRS_REG_STAT, 32'h0000_0801);
    pipe(32'h0000_0500, 32'h0000_0B00);
    rd_state(32'h0000_0104, 32'h0000_0100, 32'h0000_00FC, 32'h0000_0A00, 32'h0000_0A60,
      32'h0000_0A00);
    check({chan.data[15:0], bytePtr[15:0]}, 32'h0A00_0A00);
    check(aluStatus, 32'h0000_0A60);
  endtask : t_freeze

  // hold: {multiBusy, memBusy} kept high for a while after the request
  task automatic t_return(input logic inv, input logic [1:0] lock, input logic [1:0] hold,
    input logic [3:0] lg, input int eAcc, eMul, eClr, input logic [31:0] a1, a0,
    input logic br2, input logic [31:0] eSt);
    int n;
    int adv;
    n = 0;
    adv = 0;
    @(posedge clk);
    icLocked <= lock;
    lag <= lg;
    {multiBusy, memBusy} <= hold;
    clrLog <= 1'b1;
    @(posedge clk);
    clrLog <= 1'b0;
    retReq <= 1'b1;
    retInv <= inv;
    @(posedge clk);
    retReq <= 1'b0;
    if (hold != 2'h0) begin
      repeat (20) @(posedge clk);
      #1 check({30'h0, trapBlock, fetch.req}, 32'h0);
      @(posedge clk);
      {multiBusy, memBusy} <= 2'h0;
    end
    while (retDone !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      if (fetch.req === 1'b1) check(trapBlock, 32'h1);
      if (pipeAdv === 1'b1) adv++;
      n++;
    end
    check(n < 400, 32'h1);
    check(adv, 1);
    check(trapBlock, 32'h0);
    check(curStatus, eSt);
    check(i_part.fCnt, 2);
    check(i_part.fAddr[0], a1);
    check(i_part.fBr[0], 32'h1);
    check(i_part.fAddr[1], a0);
    check(i_part.fBr[1], br2);
    check(i_part.accCnt, eAcc);
    check(i_part.multiCnt, eMul);
    check(i_part.clrCnt, eClr);
    check(i_part.lockHit, 0);
    check(i_part.fClr[0], eClr);
  endtask : t_return

  task automatic t_assert(input logic sup, input logic [7:0] v, input logic f,
    input logic [1:0] e);
    wr(`IRS_REG_CPS, sup ? 32'h0000_0010 : 32'h0000_0000);
    @(posedge clk);
    asrtOp <= 1'b1;
    asrtVec <= v;
    asrtFires <= f;
    @(posedge clk);
    asrtOp <= 1'b0;
    #1 check({30'h0, protViol, vecTrap}, e);
    if (e[0]) check(trapVec, v);
  endtask : t_assert

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #300000;
    errors++;
    end_of_test();
  end

  initial begin
    {regWr, regRd, retReq, retInv, memBusy, multiBusy, trapTake, hwIntPend} = '0;
    {decAdv, exeAdv, wbAdv, chWe, aluWe, carryWe, divWe, lsSetBp, asrtOp, asrtFires} = '0;
    {regAddr, lag, regWdata, decPc, exePc, wbPc, aluIn, lsBp, icLocked, asrtVec} = '0;
    chIn = '0;
    clrLog = 1'b0;
    {carryIn, divIn} = 2'h3;
    errors = 0;
    samplesChecked = 0;
    srst = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdchk(`IRS_REG_CPS, 32'h0000_0410);
    rdchk(4'hB, 32'h0000_0000);
    rdchk(`IRS_REG_STAT, 32'h0000_0001);
    rd_state('0, '0, '0, '0, '0, '0);
    t_freeze();
    hwIntPend <= 1'b1;
    t_return(1'b0, 2'h0, 2'h0, 4'h0, 0, 0, 0, 32'h0000_0100, 32'h0000_0104, 1'b0,
      32'h0000_4010);
    hwIntPend <= 1'b0;
    wr(`IRS_REG_OPS, 32'h0000_0000);
    wr(`IRS_REG_PC1, 32'h0000_0203);
    wr(`IRS_REG_PC0, 32'h0000_0303);
    wr(`IRS_REG_CHC, 32'h0000_0001);
    rdchk(`IRS_REG_PC1, 32'h0000_0200);
    t_return(1'b1, 2'h2, 2'h1, 4'h0, 1, 0, 32, 32'h0000_0200, 32'h0000_0300, 1'b1,
      32'h0000_0000);
    wr(`IRS_REG_OPS, 32'h0000_0010);
    wr(`IRS_REG_CHC, 32'h0000_0005);
    t_return(1'b0, 2'h0, 2'h2, 4'h3, 0, 1, 0, 32'h0000_0200, 32'h0000_0300, 1'b1,
      32'h0000_0010);
    wr(`IRS_REG_CHC, 32'h0000_0003);
    t_return(1'b1, 2'h0, 2'h0, 4'h1, 0, 0, 64, 32'h0000_0200, 32'h0000_0300, 1'b1,
      32'h0000_0010);
    t_assert(1'b0, 8'h11, 1'b1, 2'h2);
    t_assert(1'b0, 8'h40, 1'b1, 2'h1);
    t_assert(1'b1, 8'h11, 1'b1, 2'h1);
    t_assert(1'b1, 8'h3F, 1'b0, 2'h0);
    end_of_test();
  end
endmodule : tb_top
